// ===== amd_decoder.sv
// Addressing-mode decoder: fetches prebyte, opcode, address bytes and
// pointers, then reports mode, length, effective address and branch target.
// Assumes one byte-wide memory port that answers each request with bus_valid.
`timescale 1ns/10ps

module amd_decoder (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            dec_start,
    input  wire logic [15:0]     pc_in,
    input  wire logic [7:0]      idx_x,
    input  wire logic [7:0]      idx_y,
    input  wire logic            bus_valid,
    input  wire logic [7:0]      bus_rdata,
    output amd_pkg::amd_bus_t    bus,
    output logic                 dec_busy,
    output logic                 dec_valid,
    output amd_pkg::amd_result_t result
);
    import amd_pkg::*;

    amd_state_t  state;
    amd_dec_t    dec;
    amd_dec_t    next_dec;
    amd_result_t next_result;
    logic [15:0] pc;
    logic [7:0]  pre;
    logic [7:0]  opc;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [15:0] ptr;
    logic [1:0]  cnt;

    // =========================================================
    // opcode and prebyte to mode
    function automatic amd_dec_t decode_op(input logic [7:0] op, input logic [7:0] pb);
        amd_dec_t d;
        logic     ind;
        logic     iy;
        logic     ok_ind;
        d      = '0;
        ind    = (pb == PRE_INDIRECT_X) || (pb == PRE_INDIRECT_Y);
        iy     = (pb == PRE_INDIRECT_Y);
        ok_ind = 1'b0;
        case (op[7:4])
            GRP_BIT_REL: begin
                d.mode = ind ? MODE_BIT_IR : MODE_BIT_DR;
                ok_ind = !iy;
            end
            GRP_BIT_SET: begin
                d.mode = ind ? MODE_BIT_I : MODE_BIT_D;
                ok_ind = !iy;
            end
            GRP_REL: begin
                d.mode = ind ? MODE_REL_I : MODE_REL_D;
                ok_ind = !iy;
            end
            GRP_RMW_DIR, GRP_DIR_S: begin
                d.mode = ind ? MODE_IND_S : MODE_DIR_S;
                ok_ind = !iy;
            end
            GRP_RMW_IDX_S, GRP_IDX_S: begin
                d.mode = ind ? MODE_INDX_S : MODE_IDX_S;
                ok_ind = 1'b1;
            end
            GRP_RMW_IDX0, GRP_IDX0: begin
                d.mode = MODE_IDX0; // no indirect form without an offset
            end
            GRP_IMM: begin
                d.mode = MODE_IMM;
            end
            GRP_DIR_L: begin
                d.mode = ind ? MODE_IND_L : MODE_DIR_L;
                ok_ind = !iy;
            end
            GRP_IDX_L: begin
                d.mode = ind ? MODE_INDX_L : MODE_IDX_L;
                ok_ind = 1'b1;
            end
            default: begin
                d.mode = MODE_INH;
            end
        endcase
        // y select only from the accumulator rmw group up; indirect prebytes only where a form exists
        d.illegal = (ind && !ok_ind) ||
                    ((pb == PRE_Y_SELECT) && (op[7:4] < GRP_RMW_ACC));
        d.use_y   = (pb == PRE_Y_SELECT) || iy;
        if (d.illegal) begin
            d.mode = MODE_INH;
        end
        // bytes after the opcode and bytes read through a pointer
        case (d.mode)
            MODE_INH, MODE_IDX0: begin
                d.nargs = 2'd0;
                d.nptr  = 2'd0;
            end
            MODE_IMM, MODE_DIR_S, MODE_IDX_S, MODE_REL_D, MODE_BIT_D: begin
                d.nargs = 2'd1;
                d.nptr  = 2'd0;
            end
            MODE_DIR_L, MODE_IDX_L: begin
                d.nargs = 2'd2;
                d.nptr  = 2'd0;
            end
            MODE_IND_S, MODE_INDX_S, MODE_REL_I, MODE_BIT_I: begin
                d.nargs = 2'd1;
                d.nptr  = 2'd1;
            end
            MODE_IND_L, MODE_INDX_L: begin
                d.nargs = 2'd1;
                d.nptr  = 2'd2;
            end
            MODE_BIT_DR: begin
                d.nargs = 2'd2;
                d.nptr  = 2'd0;
            end
            MODE_BIT_IR: begin
                d.nargs = 2'd2;
                d.nptr  = 2'd1;
            end
            default: begin
                d.nargs = 2'd0;
                d.nptr  = 2'd0;
            end
        endcase
        return d;
    endfunction

    function automatic logic [15:0] sext8(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction

    // decode of the byte on the bus while the opcode is awaited
    always_comb begin
        next_dec = decode_op(bus_rdata, pre);
    end

    // =========================================================
    // effective address, target and length from the gathered bytes
    always_comb begin
        logic [7:0] idx;
        idx                 = dec.use_y ? idx_y : idx_x;
        next_result         = '0;
        next_result.illegal = dec.illegal;
        next_result.use_y   = dec.use_y;
        next_result.mode    = dec.mode;
        next_result.prebyte = pre;
        next_result.opcode  = opc;
        next_result.len     = 3'd1 + {2'b00, pre != PRE_NONE} + {1'b0, dec.nargs};
        case (dec.mode)
            MODE_IMM: begin
                next_result.operand = b1;
            end
            MODE_DIR_S, MODE_BIT_D: begin
                next_result.ea = {PAGE0_HI, b1};
            end
            MODE_DIR_L: begin
                next_result.ea = {b1, b2};
            end
            MODE_IDX0: begin
                next_result.ea = {PAGE0_HI, idx};
            end
            MODE_IDX_S: begin
                next_result.ea = {PAGE0_HI, b1} + {PAGE0_HI, idx};
            end
            MODE_IDX_L: begin
                next_result.ea = {b1, b2} + {PAGE0_HI, idx};
            end
            MODE_IND_S, MODE_BIT_I: begin
                next_result.ea = {PAGE0_HI, ptr[7:0]};
            end
            MODE_IND_L: begin
                next_result.ea = ptr;
            end
            MODE_INDX_S: begin
                next_result.ea = {PAGE0_HI, ptr[7:0]} + {PAGE0_HI, idx};
            end
            MODE_INDX_L: begin
                next_result.ea = ptr + {PAGE0_HI, idx};
            end
            MODE_REL_D: begin
                next_result.target = pc + sext8(b1);
            end
            MODE_REL_I: begin
                next_result.target = pc + sext8(ptr[7:0]);
            end
            MODE_BIT_DR: begin
                next_result.ea     = {PAGE0_HI, b1};
                next_result.target = pc + sext8(b2);
            end
            MODE_BIT_IR: begin
                next_result.ea     = {PAGE0_HI, ptr[7:0]};
                next_result.target = pc + sext8(b2);
            end
            default: begin
                next_result.ea = 16'h0000; // inherent: no address
            end
        endcase
    end

    // =========================================================
    // fetch sequencer: prebyte, opcode, address bytes, pointer reads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            bus       <= '0;
            dec       <= '0;
            pc        <= 16'h0000;
            pre       <= 8'h00;
            opc       <= 8'h00;
            b1        <= 8'h00;
            b2        <= 8'h00;
            ptr       <= 16'h0000;
            cnt       <= 2'd0;
            dec_busy  <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (dec_start) begin
                        pc        <= pc_in;
                        pre       <= PRE_NONE;
                        bus.req   <= 1'b1;
                        bus.fetch <= 1'b1;
                        bus.addr  <= pc_in;
                        dec_busy  <= 1'b1;
                        state     <= ST_OP;
                    end
                end
                ST_OP: begin
                    if (bus_valid) begin
                        pc       <= pc + 16'h0001;
                        bus.addr <= pc + 16'h0001;
                        if ((pre == PRE_NONE) && ((bus_rdata == PRE_Y_SELECT) ||
                            (bus_rdata == PRE_INDIRECT_X) || (bus_rdata == PRE_INDIRECT_Y))) begin
                            pre <= bus_rdata;
                        end else begin
                            opc <= bus_rdata;
                            dec <= next_dec;
                            ptr <= 16'h0000;
                            cnt <= 2'd0;
                            if (next_dec.nargs == 2'd0) begin
                                bus.req <= 1'b0;
                                state   <= ST_FIN;
                            end else begin
                                state <= ST_ARG;
                            end
                        end
                    end
                end
                ST_ARG: begin
                    if (bus_valid) begin
                        pc       <= pc + 16'h0001;
                        bus.addr <= pc + 16'h0001;
                        if (cnt == 2'd0) begin
                            b1 <= bus_rdata;
                        end else begin
                            b2 <= bus_rdata;
                        end
                        if (cnt + 2'd1 == dec.nargs) begin
                            cnt <= 2'd0;
                            if (dec.nptr != 2'd0) begin
                                // pointer lives in page zero at the first address byte
                                bus.fetch <= 1'b0;
                                bus.addr  <= {PAGE0_HI, (cnt == 2'd0) ? bus_rdata : b1};
                                state     <= ST_PTR;
                            end else begin
                                bus.req <= 1'b0;
                                state   <= ST_FIN;
                            end
                        end else begin
                            cnt <= cnt + 2'd1;
                        end
                    end
                end
                ST_PTR: begin
                    if (bus_valid) begin
                        ptr <= {ptr[7:0], bus_rdata}; // word pointer: high byte first
                        if (cnt + 2'd1 == dec.nptr) begin
                            bus.req <= 1'b0;
                            state   <= ST_FIN;
                        end else begin
                            cnt      <= cnt + 2'd1;
                            bus.addr <= {PAGE0_HI, b1 + 8'h01};
                        end
                    end
                end
                ST_FIN: begin
                    bus.fetch <= 1'b1;
                    dec_busy  <= 1'b0;
                    state     <= ST_IDLE;
                end
            endcase
        end
    end

    // =========================================================
    // result register and completion pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result    <= '0;
            dec_valid <= 1'b0;
        end else begin
            dec_valid <= (state == ST_FIN);
            if (state == ST_FIN) begin
                result <= next_result;
            end
        end
    end

endmodule

// ===== amd_mem_model.sv
// Behavioural program and data memory answering the decoder's byte requests.
// Assumes requests stand until bus_valid; the bench fills mem directly.
`timescale 1ns/10ps

module amd_mem_model (
    input  wire logic              clk,
    input  wire amd_pkg::amd_bus_t bus,
    input  wire logic [1:0]        wait_mask,
    output logic                   bus_valid,
    output logic [7:0]             bus_rdata
);
    import amd_pkg::*;

    // =========================================================
    // storage and answer logic
    logic [7:0] mem [0:65535];
    logic [1:0] phase = 2'h0;
    logic [1:0] cnt   = 2'h0;

    initial begin
        bus_valid = 1'b0;
        bus_rdata = 8'h00;
    end

    // answer after a varying wait; outside a strobe the data line toggles
    always @(posedge clk) begin
        #1;
        phase = phase + 2'h1;
        if (bus.req && cnt == 2'h0) begin
            bus_valid = 1'b1;
            bus_rdata = mem[bus.addr];
            cnt       = phase & wait_mask; // wait before the next answer
        end else begin
            bus_valid = 1'b0;
            bus_rdata = ~bus_rdata;
            if (bus.req) cnt = cnt - 2'h1;
        end
    end
endmodule

// ===== amd_pkg.sv
// Constants, types and opcode groups shared by the addressing-mode decoder.
// Assumes an 8-bit core with a 16-bit byte address space and one memory port.
package amd_pkg;

    // =========================================================
    // prebytes and page zero
    localparam logic [7:0] PRE_NONE          = 8'h00;
    localparam logic [7:0] PRE_Y_SELECT      = 8'h90; // prebyte_y_select
    localparam logic [7:0] PRE_INDIRECT_Y    = 8'h91; // prebyte_indirect_y
    localparam logic [7:0] PRE_INDIRECT_X    = 8'h92; // prebyte_indirect_x
    localparam logic [7:0] PAGE0_HI          = 8'h00;

    // =========================================================
    // opcode groups, upper nibble of the opcode
    localparam logic [3:0] GRP_BIT_REL       = 4'h0; // bit test and branch
    localparam logic [3:0] GRP_BIT_SET       = 4'h1; // bit set / reset
    localparam logic [3:0] GRP_REL           = 4'h2; // conditional_relative_branch
    localparam logic [3:0] GRP_RMW_DIR       = 4'h3; // rmw short direct
    localparam logic [3:0] GRP_RMW_ACC       = 4'h4; // rmw on accumulator
    localparam logic [3:0] GRP_RMW_IDXREG    = 4'h5; // rmw on index register
    localparam logic [3:0] GRP_RMW_IDX_S     = 4'h6; // rmw short indexed
    localparam logic [3:0] GRP_RMW_IDX0      = 4'h7; // rmw no-offset indexed
    localparam logic [3:0] GRP_MISC0         = 4'h8; // inherent
    localparam logic [3:0] GRP_MISC1         = 4'h9; // inherent
    localparam logic [3:0] GRP_IMM           = 4'ha;
    localparam logic [3:0] GRP_DIR_S         = 4'hb;
    localparam logic [3:0] GRP_DIR_L         = 4'hc;
    localparam logic [3:0] GRP_IDX_L         = 4'hd;
    localparam logic [3:0] GRP_IDX_S         = 4'he;
    localparam logic [3:0] GRP_IDX0          = 4'hf;

    // =========================================================
    // addressing modes
    typedef enum logic [4:0] {
        MODE_INH    = 5'b00000,
        MODE_IMM    = 5'b00001,
        MODE_DIR_S  = 5'b00010,
        MODE_DIR_L  = 5'b00011,
        MODE_IDX0   = 5'b00100,
        MODE_IDX_S  = 5'b00101,
        MODE_IDX_L  = 5'b00110,
        MODE_IND_S  = 5'b00111,
        MODE_IND_L  = 5'b01000,
        MODE_INDX_S = 5'b01001,
        MODE_INDX_L = 5'b01010,
        MODE_REL_D  = 5'b01011,
        MODE_REL_I  = 5'b01100,
        MODE_BIT_D  = 5'b01101,
        MODE_BIT_I  = 5'b01110,
        MODE_BIT_DR = 5'b01111,
        MODE_BIT_IR = 5'b10000
    } amd_mode_t;

    // =========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OP   = 3'b001,
        ST_ARG  = 3'b010,
        ST_PTR  = 3'b011,
        ST_FIN  = 3'b100
    } amd_state_t;

    // =========================================================
    // carriers
    typedef struct packed {
        logic      illegal;
        logic      use_y;
        amd_mode_t mode;
        logic [1:0] nargs;  // bytes after the opcode
        logic [1:0] nptr;   // bytes read through the pointer
    } amd_dec_t;

    typedef struct packed {
        logic        req;
        logic        fetch; // 1: program stream, 0: pointer read
        logic [15:0] addr;
    } amd_bus_t;

    typedef struct packed {
        logic        illegal;
        logic        use_y;
        amd_mode_t   mode;
        logic [7:0]  prebyte;
        logic [7:0]  opcode;
        logic [2:0]  len;
        logic [7:0]  operand;
        logic [15:0] ea;
        logic [15:0] target;
    } amd_result_t;

endpackage

// ===== amd_properties.sv
// Checker for the addressing-mode decoder, bound onto its top module.
// Assumes one clock, asynchronous active-low reset and registered outputs.
`timescale 1ns/10ps

module amd_properties (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 dec_start,
    input wire logic [15:0]          pc_in,
    input wire logic [7:0]           idx_x,
    input wire logic [7:0]           idx_y,
    input wire logic                 bus_valid,
    input wire amd_pkg::amd_bus_t    bus,
    input wire logic                 dec_busy,
    input wire logic                 dec_valid,
    input wire amd_pkg::amd_result_t result
);
    import amd_pkg::*;

    // =========================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // start while idle opens a stream fetch at the given address
    a_start_fetch: assert property (dec_start && !dec_busy |=> dec_busy && bus.req
        && bus.fetch && bus.addr == $past(pc_in)) else $error("start not taken");
    a_req_hold: assert property (bus.req && !bus_valid |=> bus.req
        && $stable(bus.addr) && $stable(bus.fetch)) else $error("request dropped early");
    a_ptr_page0: assert property (bus.req && !bus.fetch
        |-> bus.addr[15:8] == PAGE0_HI) else $error("pointer read off page zero");
    a_len_range: assert property (dec_valid |-> result.len inside {[3'h1:3'h4]}
        && !dec_busy) else $error("length out of range");
    a_inh_len: assert property (dec_valid && result.mode == MODE_INH |->
        result.len == (result.prebyte != PRE_NONE ? 3'h2 : 3'h1)) else $error("inh len");
    a_one_arg: assert property (
        dec_valid && result.mode inside {MODE_IMM, MODE_DIR_S,
        MODE_IDX_S, MODE_REL_D, MODE_BIT_D, MODE_IND_S, MODE_IND_L, MODE_INDX_S, MODE_INDX_L,
        MODE_REL_I, MODE_BIT_I} |-> result.len == (result.prebyte != PRE_NONE ? 3'h3 : 3'h2))
        else $error("one-byte form len");
    a_two_arg: assert property (dec_valid && result.mode inside {MODE_DIR_L,
        MODE_IDX_L, MODE_BIT_DR, MODE_BIT_IR} |-> result.len ==
        (result.prebyte != PRE_NONE ? 3'h4 : 3'h3)) else $error("two-byte form len");
    // indexes were taken on the finish edge, one edge before the pulse is seen
    a_idx0_ea: assert property (dec_valid && result.mode == MODE_IDX0 |->
        result.ea == {PAGE0_HI, result.use_y ? $past(idx_y) : $past(idx_x)})
        else $error("idx0 ea");
    a_short_sum: assert property (dec_valid
        && result.mode inside {MODE_IDX_S, MODE_INDX_S} |-> result.ea <= 16'h01fe)
        else $error("short sum range");
    a_y_select: assert property (dec_valid && result.prebyte == PRE_Y_SELECT
        && !result.illegal |-> result.use_y && result.mode inside {MODE_INH, MODE_IMM,
        MODE_DIR_S, MODE_DIR_L, MODE_IDX0, MODE_IDX_S, MODE_IDX_L}) else $error("y prebyte");
    a_ind_x: assert property (dec_valid && result.prebyte == PRE_INDIRECT_X
        && !result.illegal |-> !result.use_y && result.mode inside {MODE_IND_S, MODE_IND_L,
        MODE_INDX_S, MODE_INDX_L, MODE_REL_I, MODE_BIT_I, MODE_BIT_IR})
        else $error("ind prebyte");
    a_ind_y: assert property (dec_valid && result.prebyte == PRE_INDIRECT_Y
        && !result.illegal |-> result.use_y && result.mode inside {MODE_INDX_S, MODE_INDX_L})
        else $error("ind y prebyte");
endmodule

bind amd_decoder amd_properties u_props (.clk(clk), .rst_n(rst_n), .dec_start(dec_start),
    .pc_in(pc_in), .idx_x(idx_x), .idx_y(idx_y), .bus_valid(bus_valid), .bus(bus),
    .dec_busy(dec_busy), .dec_valid(dec_valid), .result(result));

// ===== amd_tb.sv
// Self-checking bench for the addressing-mode decoder against a reference model.
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/10ps

module tb;
    import amd_pkg::*;

    // =========================================================
    // signals and instances
    logic        clk = 1'b0;
    logic        rst_n, dec_start, bus_valid, dec_busy, dec_valid;
    logic [15:0] pc_in;
    logic [7:0]  idx_x, idx_y, bus_rdata;
    logic [1:0]  wait_mask;
    amd_bus_t    bus;
    amd_result_t result, exp_r;
    int          bad_count, samples_checked, xfers, seed;
    logic [7:0]  pre_tab [4] = '{8'h00, 8'h90, 8'h91, 8'h92};

    amd_decoder dut (.clk(clk), .rst_n(rst_n), .dec_start(dec_start), .pc_in(pc_in),
        .idx_x(idx_x), .idx_y(idx_y), .bus_valid(bus_valid), .bus_rdata(bus_rdata),
        .bus(bus), .dec_busy(dec_busy), .dec_valid(dec_valid), .result(result));
    amd_mem_model mdl (.clk(clk), .bus(bus), .wait_mask(wait_mask), .bus_valid(bus_valid),
        .bus_rdata(bus_rdata));

    // clock and transfer counter
    always #12.5 clk = ~clk;
    always @(posedge clk) if (bus.req && bus_valid) xfers <= xfers + 1;

    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // reference decode from the instruction bytes
    function automatic amd_result_t ref_dec(input logic [7:0] pre, op, b1, b2, p1, p2,
            input logic [15:0] pc, input logic [7:0] ix, iy, output int nb);
        amd_result_t r;
        int          g, na;
        bit          ind, y, bad;
        logic [15:0] nx, nxt;
        r = '0;
        g = op[7:4];
        ind = pre inside {8'h91, 8'h92};
        y = pre inside {8'h90, 8'h91};
        bad = (pre == 8'h90 && g < 4) || (pre == 8'h91 && !(g inside {6, 13, 14}))
            || (pre == 8'h92 && !(g inside {0, 1, 2, 3, 6, 11, 12, 13, 14}));
        na = 1;
        nb = ind;
        case (g)
            0: begin r.mode = ind ? MODE_BIT_IR : MODE_BIT_DR; na = 2; end
            1: r.mode = ind ? MODE_BIT_I : MODE_BIT_D;
            2: r.mode = ind ? MODE_REL_I : MODE_REL_D;
            3, 11: r.mode = ind ? MODE_IND_S : MODE_DIR_S;
            6, 14: r.mode = ind ? MODE_INDX_S : MODE_IDX_S;
            7, 15: begin r.mode = MODE_IDX0; na = 0; end
            10: r.mode = MODE_IMM;
            // long indirect forms carry only a pointer-address byte after the opcode
            12: begin r.mode = ind ? MODE_IND_L : MODE_DIR_L; na = ind ? 1 : 2; nb = 2 * ind; end
            13: begin r.mode = ind ? MODE_INDX_L : MODE_IDX_L; na = ind ? 1 : 2; nb = 2 * ind; end
            default: begin r.mode = MODE_INH; na = 0; end
        endcase
        // an illegal pairing still reports the index choice of its prebyte
        if (bad) begin r.mode = MODE_INH; na = 0; nb = 0; end
        r.illegal = bad;
        r.use_y = y;
        r.prebyte = pre;
        r.opcode = op;
        r.len = 3'(1 + (pre != 8'h00) + na);
        nx = {8'h00, y ? iy : ix};
        nxt = pc + 16'(r.len);
        case (r.mode)
            MODE_IMM: r.operand = b1;
            MODE_DIR_S, MODE_BIT_D: r.ea = {8'h00, b1};
            MODE_BIT_DR: begin r.ea = {8'h00, b1}; r.target = nxt + {{8{b2[7]}}, b2}; end
            MODE_DIR_L: r.ea = {b1, b2};
            MODE_IDX0: r.ea = nx;
            MODE_IDX_S: r.ea = {8'h00, b1} + nx;
            MODE_IDX_L: r.ea = {b1, b2} + nx;
            MODE_IND_S, MODE_BIT_I: r.ea = {8'h00, p1};
            MODE_BIT_IR: begin r.ea = {8'h00, p1}; r.target = nxt + {{8{b2[7]}}, b2}; end
            MODE_IND_L: r.ea = {p1, p2};
            MODE_INDX_S: r.ea = {8'h00, p1} + nx;
            MODE_INDX_L: r.ea = {p1, p2} + nx;
            MODE_REL_D: r.target = nxt + {{8{b1[7]}}, b1};
            MODE_REL_I: r.target = nxt + {{8{p1[7]}}, p1};
            default: ;
        endcase
        return r;
    endfunction

    // place one instruction, decode it and compare; bnd forces all-ones bytes
    task automatic run(input logic [7:0] pre, input logic [7:0] op, input bit bnd,
            input bit poke);
        logic [15:0] pc, a;
        logic [7:0]  b1, b2, p1, p2, ix, iy;
        int          nb, x0, n;
        amd_result_t got;
        pc = 16'($random(seed));
        pc[15:14] = 2'b10; // keep the stream off page zero
        {b1, b2, p1, p2} = $random(seed);
        {ix, iy} = 16'($random(seed));
        if (bnd) {b1, b2, p1, p2, ix, iy} = 48'hffff_ffff_ffff;
        if (pre == 8'h00 && op[7:2] == 6'b100100) op[3] = 1'b1;
        a = pc;
        if (pre != 8'h00) begin mdl.mem[a] = pre; a++; end
        mdl.mem[a] = op;
        mdl.mem[a + 16'h1] = b1;
        mdl.mem[a + 16'h2] = b2;
        mdl.mem[{8'h00, b1}] = p1;
        mdl.mem[{8'h00, b1 + 8'h1}] = p2;
        exp_r = ref_dec(pre, op, b1, b2, p1, p2, pc, ix, iy, nb);
        x0 = xfers;
        idx_x = ix;
        idx_y = iy;
        pc_in = pc;
        dec_start = 1'b1;
        @(posedge clk);
        #1;
        dec_start = poke; // a start while busy must be ignored
        pc_in = ~pc;
        n = 0;
        while (dec_valid !== 1'b1) begin
            if (n == 200) begin bad_count++; stop_test(); end
            n++;
            @(posedge clk);
            #1;
            dec_start = 1'b0;
        end
        got = result;
        if (got.mode inside {MODE_REL_D, MODE_REL_I}) got.ea = '0;
        if (exp_r.mode inside {MODE_REL_D, MODE_REL_I}) exp_r.ea = '0;
        check(got, exp_r);
        check(xfers - x0, exp_r.len + nb);
    endtask

    // =========================================================
    // main sequence
    initial begin
        int r;
        seed = 32'hf70bd137;
        {rst_n, dec_start, pc_in, idx_x, idx_y, wait_mask} = '0;
        {bad_count, samples_checked, xfers} = '0;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        // every group with every prebyte, prompt then slow memory
        for (int m = 0; m < 2; m++) begin
            wait_mask = m ? 2'h3 : 2'h0;
            for (int i = 0; i < 64; i++) begin
                r = $random(seed);
                run(pre_tab[i % 4], {i[5:2], r[3:0]}, i % 3 == 0, i % 5 == 0);
            end
            $display("test sweep %0d done", m);
        end
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            run(pre_tab[r[9:8]], r[7:0], r[10], r[11]);
        end
        $display("test random done");
        // reset in mid-decode clears every output
        dec_start = 1'b1;
        @(posedge clk);
        #1 dec_start = 1'b0;
        @(posedge clk);
        #1 rst_n = 1'b0;
        #1 check({bus, dec_busy, dec_valid, result}, '0);
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 8; i++) run(pre_tab[i % 4], 8'hd0 + 8'(i), 1'b1, 1'b0);
        $display("test reset done");
        stop_test();
    end
endmodule
